// ### ict_timing.sv
// Instruction cycle timing sequencer with long multiply datapath
`timescale 1ns/1ps
// What this block does
// - Listed cycle counts hold at zero wait states, and each wait state adds one cycle.
// - Operand two is a register, an immediate- or register-shifted register, or an immediate.
// - An ALU op, single load or multiple load writing the program counter takes its base count plus the refill cycles.
// - Doubleword loads take 1 + 2 cycles and multiple loads 1 + N, plus refill when a multiple load loads the PC.
// - A barrier takes one cycle plus the cycles the barrier operation needs.
// - Wait-for-event and wait-for-interrupt hints take one cycle plus the cycles spent waiting.
// - The signed long multiply takes 3 to 5 cycles and yields a 64-bit low and high result.
// - The unsigned long multiply takes 3 to 5 cycles and yields a 64-bit low and high result.
// - The long multiply-accumulates take 4 to 7 cycles and add the product to the pair.
// - Long multiplies end early by operand size; an interrupt abandons them for a restart.
// - Division ends early, taking 2 to 12 cycles by the leading ones and zeros of its operands.
// - A single store, or a single load not writing the PC, issued right after one completes in one cycle.
module ict_timing
  import ict_pkg::*;
#(
  parameter int REFILL_CYCLES = ICT_REFILL_DEF
) (
  // Clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     reset_n_i,
  // Issue
  input  wire logic                     issue_valid_i,
  input  ict_class_t                    issue_class_i,
  input  ict_op2_form_t                 op2_form_i,
  input  wire logic                     writes_pc_i,
  input  wire logic [ICT_REGCNT_W-1:0]  reg_count_i,
  input  wire logic [ICT_DATA_W-1:0]    operand_a_i,
  input  wire logic [ICT_DATA_W-1:0]    operand_b_i,
  input  wire logic [ICT_DATA_W-1:0]    acc_lo_i,
  input  wire logic [ICT_DATA_W-1:0]    acc_hi_i,
  // Memory and system events
  input  wire logic                     mem_wait_i,
  input  wire logic                     barrier_done_i,
  input  wire logic                     wake_event_i,
  input  wire logic                     irq_i,
  // Status and results
  output logic                          issue_ready_o,
  output logic                          retire_o,
  output logic [ICT_CNT_W-1:0]          retire_cycles_o,
  output logic                          restart_o,
  output ict_op2_form_t                 op2_form_o,
  output logic [ICT_DATA_W-1:0]         result_lo_o,
  output logic [ICT_DATA_W-1:0]         result_hi_o
);

  // ==========================================================================
  // Elaboration checks
  if (REFILL_CYCLES < 1 || REFILL_CYCLES > ICT_REFILL_MAX) begin : g_bad_refill
    $error("REFILL_CYCLES out of range");
  end

  localparam logic [7:0] REFILL_C = 8'(REFILL_CYCLES);

  // ==========================================================================
  // Functions
  function automatic logic [5:0] ict_clz(input logic [ICT_DATA_W-1:0] v);
    logic [5:0] n;
    logic       found;
    n     = 6'h00;
    found = 1'b0;
    for (int i = ICT_DATA_W - 1; i >= 0; i--) begin
      if (v[i]) begin
        found = 1'b1;
      end else if (!found) begin
        n = n + 6'h01;
      end
    end
    return n;
  endfunction

  function automatic logic ict_is_single_ls(input ict_class_t c);
    return (c == ICT_CLS_LOAD_SINGLE) || (c == ICT_CLS_STORE_SINGLE);
  endfunction
  function automatic logic ict_is_long_mul(input ict_class_t c);
    return (c == ICT_CLS_SIGNED_LONG_MULTIPLY) || (c == ICT_CLS_UNSIGNED_LONG_MULTIPLY) ||
           (c == ICT_CLS_SIGNED_LONG_MULTIPLY_ACCUMULATE) ||
           (c == ICT_CLS_UNSIGNED_LONG_MULTIPLY_ACCUMULATE);
  endfunction

  function automatic logic [7:0] ict_sat_inc(input logic [7:0] v);
    return (v == ICT_CNT_MAX) ? v : v + 8'h01;
  endfunction

  // ==========================================================================
  // Reset synchroniser
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ==========================================================================
  // Registers
  ict_state_t       state_ff, nxt_state;
  ict_class_t       class_ff, nxt_class;
  ict_op2_form_t    op2_ff, nxt_op2;
  logic [7:0]       rem_ff, nxt_rem;
  logic [7:0]       elapsed_ff, nxt_elapsed;
  logic [7:0]       cycles_ff, nxt_cycles;
  logic             ready_ff, nxt_ready;
  logic             retire_ff, nxt_retire;
  logic             restart_ff, nxt_restart;
  logic             ls_tail_ff, nxt_ls_tail;
  logic [63:0]      result_ff, nxt_result;

  // ==========================================================================
  // Operand decode
  wire logic        is_signed   = (issue_class_i == ICT_CLS_SIGNED_LONG_MULTIPLY) ||
                                  (issue_class_i == ICT_CLS_SIGNED_LONG_MULTIPLY_ACCUMULATE) ||
                                  (issue_class_i == ICT_CLS_DIV_SIGNED);
  wire logic [31:0] mag_a       = (is_signed && operand_a_i[31]) ? ~operand_a_i + 32'h1
                                                                 : operand_a_i;
  wire logic [31:0] mag_b       = (is_signed && operand_b_i[31]) ? ~operand_b_i + 32'h1
                                                                 : operand_b_i;
  wire logic [31:0] sig_b       = (is_signed && operand_b_i[31]) ? ~operand_b_i : operand_b_i;
  wire logic [5:0]  lz_a        = ict_clz(mag_a);
  wire logic [5:0]  lz_b        = ict_clz(mag_b);
  wire logic [5:0]  lz_m        = ict_clz(sig_b);
  wire logic [5:0]  div_diff    = (lz_b > lz_a) ? lz_b - lz_a : 6'h00;
  wire logic [7:0]  div_q       = ({2'h0, div_diff} + ICT_DIV_XTRA_RND) / ICT_DIV_XTRA_DIV;
  wire logic [7:0]  div_extra   = (div_q > ICT_DIV_XTRA_MAX) ? ICT_DIV_XTRA_MAX : div_q;
  wire logic [7:0]  lmac_extra  = (lz_m >= ICT_LZ_BYTE1) ? 8'h00 :
                                  (lz_m >= ICT_LZ_BYTE2) ? 8'h01 :
                                  (lz_m >= ICT_LZ_BYTE3) ? 8'h02 : 8'h03;
  wire logic [7:0]  lmul_extra  = (lmac_extra > ICT_LMUL_XTRA_MAX) ? ICT_LMUL_XTRA_MAX
                                                                   : lmac_extra;
  wire logic [7:0]  refill      = writes_pc_i ? REFILL_C : 8'h00;
  wire logic [7:0]  list_regs   = {3'h0, reg_count_i};
  wire logic        overlap     = ls_tail_ff && ict_is_single_ls(issue_class_i);
  wire logic        accept      = issue_valid_i && ready_ff && !mem_wait_i;

  // ==========================================================================
  // Long multiply datapath
  wire logic [63:0] smul_prod   = 64'($signed(operand_a_i)) * 64'($signed(operand_b_i));
  wire logic [63:0] umul_prod   = 64'(operand_a_i) * 64'(operand_b_i);
  wire logic [63:0] acc_pair    = {acc_hi_i, acc_lo_i};

  // ==========================================================================
  // Cycle target selection
  logic [7:0] target;
  logic [63:0] product;

  always_comb begin
    target  = ICT_BASE_ALU;
    product = result_ff;
    case (issue_class_i)
      ICT_CLS_ALU:                               target = ICT_BASE_ALU + refill;
      ICT_CLS_MUL_ACC:                           target = ICT_BASE_MAC;
      ICT_CLS_SIGNED_LONG_MULTIPLY: begin
        target  = ICT_BASE_LMUL + lmul_extra;
        product = smul_prod;
      end
      ICT_CLS_UNSIGNED_LONG_MULTIPLY: begin
        target  = ICT_BASE_LMUL + lmul_extra;
        product = umul_prod;
      end
      ICT_CLS_SIGNED_LONG_MULTIPLY_ACCUMULATE: begin
        target  = ICT_BASE_LMAC + lmac_extra;
        product = smul_prod + acc_pair;
      end
      ICT_CLS_UNSIGNED_LONG_MULTIPLY_ACCUMULATE: begin
        target  = ICT_BASE_LMAC + lmac_extra;
        product = umul_prod + acc_pair;
      end
      ICT_CLS_DIV_SIGNED, ICT_CLS_DIV_UNSIGNED:  target = ICT_BASE_DIV + div_extra;
      ICT_CLS_LOAD_SINGLE:                       target = (overlap ? ICT_BASE_LS_OVL
                                                                   : ICT_BASE_LS) + refill;
      ICT_CLS_STORE_SINGLE:                      target = overlap ? ICT_BASE_LS_OVL
                                                                  : ICT_BASE_LS;
      ICT_CLS_LOAD_DOUBLEWORD:                   target = ICT_BASE_LIST + ICT_DOUBLE_REGS;
      ICT_CLS_LOAD_MULTIPLE:                     target = ICT_BASE_LIST + list_regs
                                                          + refill;
      default:                                   target = ICT_BASE_WAIT;
    endcase
  end

  // ==========================================================================
  // Sequencer
  wire logic wake = irq_i || (class_ff == ICT_CLS_WAIT_FOR_EVENT_HINT && wake_event_i);

  always_comb begin
    nxt_state   = state_ff;
    nxt_class   = class_ff;
    nxt_op2     = op2_ff;
    nxt_rem     = rem_ff;
    nxt_elapsed = ict_sat_inc(elapsed_ff);
    nxt_cycles  = cycles_ff;
    nxt_ready   = ready_ff;
    nxt_retire  = 1'b0;
    nxt_restart = 1'b0;
    nxt_ls_tail = 1'b0;
    nxt_result  = result_ff;
    case (state_ff)
      ICT_ST_IDLE: begin
        if (accept) begin
          nxt_class   = issue_class_i;
          nxt_op2     = op2_form_i;
          nxt_elapsed = 8'h01;
          nxt_result  = ict_is_long_mul(issue_class_i) ? product : result_ff;
          if (issue_class_i == ICT_CLS_BARRIER) begin
            nxt_state = ICT_ST_BARRIER;
            nxt_ready = 1'b0;
          end else if (issue_class_i == ICT_CLS_WAIT_FOR_EVENT_HINT ||
                       issue_class_i == ICT_CLS_WAIT_FOR_INTERRUPT_HINT) begin
            nxt_state = ICT_ST_HINT;
            nxt_ready = 1'b0;
          end else if (target == 8'h01) begin
            nxt_retire  = 1'b1;
            nxt_cycles  = 8'h01;
            nxt_ls_tail = ict_is_single_ls(issue_class_i);
          end else begin
            nxt_state = ICT_ST_COUNT;
            nxt_rem   = target - 8'h01;
            nxt_ready = 1'b0;
          end
        end
      end
      ICT_ST_COUNT: begin
        if (ict_is_long_mul(class_ff) && irq_i) begin
          nxt_state   = ICT_ST_IDLE;
          nxt_ready   = 1'b1;
          nxt_restart = 1'b1;
        end else if (!mem_wait_i) begin
          if (rem_ff == 8'h01) begin
            nxt_state   = ICT_ST_IDLE;
            nxt_ready   = 1'b1;
            nxt_retire  = 1'b1;
            nxt_cycles  = ict_sat_inc(elapsed_ff);
            nxt_ls_tail = ict_is_single_ls(class_ff);
          end else begin
            nxt_rem = rem_ff - 8'h01;
          end
        end
      end
      ICT_ST_BARRIER: begin
        if (barrier_done_i) begin
          nxt_state  = ICT_ST_IDLE;
          nxt_ready  = 1'b1;
          nxt_retire = 1'b1;
          nxt_cycles = ict_sat_inc(elapsed_ff);
        end
      end
      ICT_ST_HINT: begin
        if (wake) begin
          nxt_state  = ICT_ST_IDLE;
          nxt_ready  = 1'b1;
          nxt_retire = 1'b1;
          nxt_cycles = ict_sat_inc(elapsed_ff);
        end
      end
      default: begin
        nxt_state = ICT_ST_IDLE;
        nxt_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff   <= ICT_ST_IDLE;
      class_ff   <= ICT_CLS_ALU;
      op2_ff     <= ICT_OP2_REG;
      rem_ff     <= 8'h00;
      elapsed_ff <= 8'h00;
      cycles_ff  <= 8'h00;
      ready_ff   <= 1'b0;
      retire_ff  <= 1'b0;
      restart_ff <= 1'b0;
      ls_tail_ff <= 1'b0;
      result_ff  <= 64'h0;
    end else begin
      state_ff   <= nxt_state;
      class_ff   <= nxt_class;
      op2_ff     <= nxt_op2;
      rem_ff     <= nxt_rem;
      elapsed_ff <= nxt_elapsed;
      cycles_ff  <= nxt_cycles;
      ready_ff   <= (state_ff == ICT_ST_IDLE && !ready_ff) ? 1'b1 : nxt_ready;
      retire_ff  <= nxt_retire;
      restart_ff <= nxt_restart;
      ls_tail_ff <= nxt_ls_tail;
      result_ff  <= nxt_result;
    end
  end

  // ==========================================================================
  // Outputs
  assign issue_ready_o   = ready_ff;
  assign retire_o        = retire_ff;
  assign retire_cycles_o = cycles_ff;
  assign restart_o       = restart_ff;
  assign op2_form_o      = op2_ff;
  assign result_lo_o     = result_ff[31:0];
  assign result_hi_o     = result_ff[63:32];

endmodule

// ### ict_pkg.sv
// Constants and types for the instruction cycle timing block
package ict_pkg;

  // ==========================================================================
  // Widths and defaults
  localparam int             ICT_DATA_W       = 32;
  localparam int             ICT_CNT_W        = 8;
  localparam int             ICT_REGCNT_W     = 5;
  localparam int             ICT_REFILL_DEF   = 2;
  localparam int             ICT_REFILL_MAX   = 15;
  localparam logic [7:0]     ICT_CNT_MAX      = 8'hFF;

  // ==========================================================================
  // Base cycle counts at zero wait states
  localparam logic [7:0]     ICT_BASE_ALU     = 8'h01;
  localparam logic [7:0]     ICT_BASE_MAC     = 8'h02;
  localparam logic [7:0]     ICT_BASE_LMUL    = 8'h03;
  localparam logic [7:0]     ICT_BASE_LMAC    = 8'h04;
  localparam logic [7:0]     ICT_BASE_DIV     = 8'h02;
  localparam logic [7:0]     ICT_BASE_LS      = 8'h02;
  localparam logic [7:0]     ICT_BASE_LS_OVL  = 8'h01;
  localparam logic [7:0]     ICT_BASE_LIST    = 8'h01;
  localparam logic [7:0]     ICT_BASE_WAIT    = 8'h01;
  localparam logic [7:0]     ICT_DOUBLE_REGS  = 8'h02;

  // ==========================================================================
  // Early termination limits
  localparam logic [7:0]     ICT_LMUL_XTRA_MAX = 8'h02;
  localparam logic [7:0]     ICT_DIV_XTRA_MAX  = 8'h0A;
  localparam logic [7:0]     ICT_DIV_XTRA_RND  = 8'h02;
  localparam logic [7:0]     ICT_DIV_XTRA_DIV  = 8'h03;
  localparam logic [5:0]     ICT_LZ_BYTE1      = 6'h18;
  localparam logic [5:0]     ICT_LZ_BYTE2      = 6'h10;
  localparam logic [5:0]     ICT_LZ_BYTE3      = 6'h08;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    ICT_CLS_ALU,
    ICT_CLS_MUL_ACC,
    ICT_CLS_SIGNED_LONG_MULTIPLY,
    ICT_CLS_UNSIGNED_LONG_MULTIPLY,
    ICT_CLS_SIGNED_LONG_MULTIPLY_ACCUMULATE,
    ICT_CLS_UNSIGNED_LONG_MULTIPLY_ACCUMULATE,
    ICT_CLS_DIV_SIGNED,
    ICT_CLS_DIV_UNSIGNED,
    ICT_CLS_LOAD_SINGLE,
    ICT_CLS_STORE_SINGLE,
    ICT_CLS_LOAD_DOUBLEWORD,
    ICT_CLS_LOAD_MULTIPLE,
    ICT_CLS_BARRIER,
    ICT_CLS_WAIT_FOR_EVENT_HINT,
    ICT_CLS_WAIT_FOR_INTERRUPT_HINT
  } ict_class_t;

  typedef enum logic [1:0] {
    ICT_OP2_REG,
    ICT_OP2_IMM_SHIFTED_REG,
    ICT_OP2_REG_SHIFTED_REG,
    ICT_OP2_IMM
  } ict_op2_form_t;

  typedef enum logic [1:0] {
    ICT_ST_IDLE,
    ICT_ST_COUNT,
    ICT_ST_BARRIER,
    ICT_ST_HINT
  } ict_state_t;

endpackage

// ### ict_timing_properties.sv
// Timing checker for the instruction cycle timing block
`timescale 1ns/1ps
module ict_timing_properties
  import ict_pkg::*;
#(
  parameter int REFILL_CYCLES = ICT_REFILL_DEF
) (
  // Clock, reset and issue
  input  wire logic                    mclk_i,
  input  wire logic                    reset_n_i,
  input  wire logic                    issue_valid_i,
  input  ict_class_t                   issue_class_i,
  input  ict_op2_form_t                op2_form_i,
  input  wire logic                    writes_pc_i,
  input  wire logic [ICT_REGCNT_W-1:0] reg_count_i,
  // Events
  input  wire logic                    mem_wait_i,
  input  wire logic                    barrier_done_i,
  input  wire logic                    wake_event_i,
  input  wire logic                    irq_i,
  // Status
  input  wire logic                    issue_ready_o,
  input  wire logic                    retire_o,
  input  wire logic [ICT_CNT_W-1:0]    retire_cycles_o,
  input  wire logic                    restart_o,
  input  ict_op2_form_t                op2_form_o
);
  // ==========================================================================
  // Tracking of the instruction in flight
  ict_class_t cls_ff;
  logic       fly_ff;
  logic       ovl_ff;
  logic [7:0] pen_ff;
  logic [7:0] cnt_ff;
  logic [7:0] wcnt_ff;
  logic [4:0] n_ff;
  logic       take;
  logic       busy;
  logic       sgl;
  logic       lm;
  logic [7:0] base;
  assign take = issue_valid_i && issue_ready_o && !mem_wait_i;
  assign busy = fly_ff && !issue_ready_o;
  assign sgl  = cls_ff inside {ICT_CLS_LOAD_SINGLE, ICT_CLS_STORE_SINGLE};
  assign lm   = cls_ff inside {[ICT_CLS_SIGNED_LONG_MULTIPLY:
                                ICT_CLS_UNSIGNED_LONG_MULTIPLY_ACCUMULATE]};
  assign base = cnt_ff - wcnt_ff;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cls_ff  <= ICT_CLS_ALU;
      fly_ff  <= 1'b0;
      ovl_ff  <= 1'b0;
      pen_ff  <= 8'h00;
      cnt_ff  <= 8'h00;
      wcnt_ff <= 8'h00;
      n_ff    <= 5'h00;
    end else if (take) begin
      cls_ff  <= issue_class_i;
      fly_ff  <= 1'b1;
      ovl_ff  <= retire_o && sgl;
      pen_ff  <= writes_pc_i ? 8'(REFILL_CYCLES) : 8'h00;
      cnt_ff  <= 8'h01;
      wcnt_ff <= 8'h00;
      n_ff    <= reg_count_i;
    end else begin
      fly_ff  <= fly_ff && !retire_o && !restart_o;
      cnt_ff  <= cnt_ff + 8'h01;
      wcnt_ff <= wcnt_ff + {7'h00, mem_wait_i};
    end
  end

  // ==========================================================================
  // Assertions
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  property p_total; retire_o |-> retire_cycles_o == cnt_ff; endproperty
  a_total: assert property (p_total)
    else $error("retire count differs from elapsed cycles");
  property p_alu; retire_o && cls_ff == ICT_CLS_ALU |-> base == 8'h01 + pen_ff; endproperty
  a_alu: assert property (p_alu)
    else $error("single cycle op count wrong");
  property p_lmul; retire_o && lm && cls_ff < ICT_CLS_SIGNED_LONG_MULTIPLY_ACCUMULATE
    |-> base inside {[3:5]}; endproperty
  a_lmul: assert property (p_lmul)
    else $error("long multiply count out of range");
  property p_lmac; retire_o && lm && cls_ff > ICT_CLS_UNSIGNED_LONG_MULTIPLY
    |-> base inside {[4:7]}; endproperty
  a_lmac: assert property (p_lmac)
    else $error("long accumulate count out of range");
  property p_div; retire_o && cls_ff inside {ICT_CLS_DIV_SIGNED, ICT_CLS_DIV_UNSIGNED}
    |-> base inside {[2:12]}; endproperty
  a_div: assert property (p_div)
    else $error("divide count out of range");
  property p_list; retire_o && cls_ff == ICT_CLS_LOAD_MULTIPLE
    |-> base == 8'h01 + {3'h0, n_ff} + pen_ff; endproperty
  a_list: assert property (p_list)
    else $error("load multiple count wrong");
  property p_single; retire_o && sgl |-> base == (ovl_ff ? 8'h01 : 8'h02)
    + (cls_ff == ICT_CLS_LOAD_SINGLE ? pen_ff : 8'h00); endproperty
  a_single: assert property (p_single)
    else $error("single load or store count wrong");
  property p_op2; take |=> op2_form_o == $past(op2_form_i); endproperty
  a_op2: assert property (p_op2)
    else $error("operand form not captured");
  property p_restart; busy && lm && irq_i |=> restart_o && !retire_o; endproperty
  a_restart: assert property (p_restart)
    else $error("long multiply not abandoned");
  property p_barrier; busy && cls_ff == ICT_CLS_BARRIER && barrier_done_i |=> retire_o; endproperty
  a_barrier: assert property (p_barrier)
    else $error("barrier did not retire");
  property p_hint; busy && (cls_ff == ICT_CLS_WAIT_FOR_EVENT_HINT && wake_event_i
    || cls_ff == ICT_CLS_WAIT_FOR_INTERRUPT_HINT && irq_i) |=> retire_o; endproperty
  a_hint: assert property (p_hint)
    else $error("hint did not wake");
  property p_hold; take && !(issue_class_i inside {ICT_CLS_ALU, ICT_CLS_LOAD_SINGLE,
    ICT_CLS_STORE_SINGLE}) |=> !issue_ready_o; endproperty
  a_hold: assert property (p_hold)
    else $error("multi cycle op did not hold issue");
endmodule

bind ict_timing ict_timing_properties #(.REFILL_CYCLES(REFILL_CYCLES)) u_props (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .issue_valid_i(issue_valid_i),
  .issue_class_i(issue_class_i), .op2_form_i(op2_form_i), .writes_pc_i(writes_pc_i),
  .reg_count_i(reg_count_i), .mem_wait_i(mem_wait_i), .barrier_done_i(barrier_done_i),
  .wake_event_i(wake_event_i), .irq_i(irq_i), .issue_ready_o(issue_ready_o),
  .retire_o(retire_o), .retire_cycles_o(retire_cycles_o), .restart_o(restart_o),
  .op2_form_o(op2_form_o)
);

// ### ict_mem_model.sv
// Memory side model giving barrier completion and wake events after a delay
`timescale 1ns/1ps
module ict_mem_model
  import ict_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  // Control
  input  wire logic       arm_i,
  input  wire logic [7:0] delay_i,
  // Event
  output logic            done_o
);
  logic [7:0] cnt_ff;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_ff <= 8'h00;
    end else if (arm_i) begin
      cnt_ff <= delay_i;
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end
  assign done_o = cnt_ff == 8'h01;
endmodule

// ### ict_timing_test.sv
// Self-checking bench for the instruction cycle timing block
`timescale 1ns/1ps
module ict_timing_test
  import ict_pkg::*;
;
  localparam int P = 3;
  logic          mclk_i = 1'b0;
  logic          reset_n_i = 1'b0;
  logic          valid = 1'b0;
  logic          pc = 1'b0;
  logic          mwait = 1'b0;
  logic          irq = 1'b0;
  logic          arm = 1'b0;
  ict_class_t    cls = ICT_CLS_ALU;
  ict_op2_form_t form = ICT_OP2_REG;
  logic [4:0]    nreg = 5'h00;
  logic [31:0]   opa = 32'h0;
  logic [31:0]   opb = 32'h0;
  logic [31:0]   alo = 32'h89ABCDEF;
  logic [31:0]   ahi = 32'h01234567;
  logic [7:0]    dly = 8'h03;
  logic          done, ready, retire, restart;
  logic [7:0]    rcyc;
  ict_op2_form_t form_o;
  logic [31:0]   rlo, rhi;
  int            n_mismatch = 0;
  int            checked = 0;

  always #4 mclk_i = ~mclk_i;

  ict_timing #(.REFILL_CYCLES(P)) u_dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .issue_valid_i(valid), .issue_class_i(cls),
    .op2_form_i(form), .writes_pc_i(pc), .reg_count_i(nreg), .operand_a_i(opa),
    .operand_b_i(opb), .acc_lo_i(alo), .acc_hi_i(ahi), .mem_wait_i(mwait),
    .barrier_done_i(done), .wake_event_i(done), .irq_i(irq), .issue_ready_o(ready),
    .retire_o(retire), .retire_cycles_o(rcyc), .restart_o(restart), .op2_form_o(form_o),
    .result_lo_o(rlo), .result_hi_o(rhi));
  ict_mem_model u_mem (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .arm_i(arm), .delay_i(dly),
    .done_o(done));

  // ==========================================================================
  // Shared tasks
  task automatic cmp(input string s, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", s, e, g);
    end
  endtask
  task automatic issue(input ict_class_t c, input logic w, input logic [4:0] n,
                       input logic [31:0] b);
    int k;
    k = 0;
    @(posedge mclk_i);
    {valid, cls, pc, nreg, opa, opb} <= {1'b1, c, w, n, 32'h80010001, b};
    arm <= c inside {ICT_CLS_BARRIER, ICT_CLS_WAIT_FOR_EVENT_HINT};
    do begin
      @(negedge mclk_i);
      k++;
    end while (!(ready === 1'b1 && !mwait) && k < 50);
    @(posedge mclk_i);
    {valid, arm} <= 2'b00;
  endtask
  task automatic fin(input string s, input int k0, input logic [7:0] e);
    int k;
    k = k0;
    do begin
      @(negedge mclk_i);
      k++;
    end while (retire !== 1'b1 && k < 300);
    cmp(s, e, rcyc);
    cmp(s, e, k[7:0]);
  endtask
  task automatic op(input string s, input ict_class_t c, input logic w, input logic [4:0] n,
                    input logic [31:0] b, input logic [7:0] e);
    issue(c, w, n, b);
    fin(s, 0, e);
  endtask
  function automatic logic [63:0] prod(input logic sg, input logic [31:0] b);
    logic [63:0] xa;
    logic [63:0] xb;
    xa = {{32{sg}}, 32'h80010001};
    xb = {{32{sg & b[31]}}, b};
    return xa * xb;
  endfunction
  task automatic mul(input ict_class_t c, input logic sg, input logic ac, input logic [31:0] b,
                     input logic [7:0] e);
    op("long mul", c, 1'b0, 5'h00, b, e);
    cmp("long mul result", prod(sg, b) + (ac ? {ahi, alo} : 64'h0), {rhi, rlo});
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_forms;
    for (int f = 0; f < 4; f++) begin
      @(posedge mclk_i);
      form <= ict_op2_form_t'(f);
      op("alu", ICT_CLS_ALU, 1'b0, 5'h00, 32'h1, 8'h01);
      cmp("op2 form", 64'(f), form_o);
    end
  endtask
  task automatic t_loads;
    op("alu to pc", ICT_CLS_ALU, 1'b1, 5'h00, 32'h1, 8'(1 + P));
    op("load to pc", ICT_CLS_LOAD_SINGLE, 1'b1, 5'h00, 32'h1, 8'(2 + P));
    issue(ICT_CLS_LOAD_SINGLE, 1'b0, 5'h00, 32'h1);
    op("overlap", ICT_CLS_STORE_SINGLE, 1'b0, 5'h00, 32'h1, 8'h01);
    op("doubleword", ICT_CLS_LOAD_DOUBLEWORD, 1'b0, 5'h02, 32'h1, 8'h03);
    op("multiple", ICT_CLS_LOAD_MULTIPLE, 1'b0, 5'h10, 32'h1, 8'h11);
    op("multiple pc", ICT_CLS_LOAD_MULTIPLE, 1'b1, 5'h04, 32'h1, 8'(5 + P));
  endtask
  task automatic t_mul;
    mul(ICT_CLS_UNSIGNED_LONG_MULTIPLY, 1'b0, 1'b0, 32'h00000012, 8'h03);
    mul(ICT_CLS_UNSIGNED_LONG_MULTIPLY, 1'b0, 1'b0, 32'h00001234, 8'h04);
    mul(ICT_CLS_UNSIGNED_LONG_MULTIPLY, 1'b0, 1'b0, 32'h12345678, 8'h05);
    mul(ICT_CLS_SIGNED_LONG_MULTIPLY, 1'b1, 1'b0, 32'hFFFFFFFE, 8'h03);
    mul(ICT_CLS_UNSIGNED_LONG_MULTIPLY_ACCUMULATE, 1'b0, 1'b1, 32'h000000FF, 8'h04);
    mul(ICT_CLS_SIGNED_LONG_MULTIPLY_ACCUMULATE, 1'b1, 1'b1, 32'hFFFFFF80, 8'h04);
  endtask
  task automatic t_div;
    op("udiv long", ICT_CLS_DIV_UNSIGNED, 1'b0, 5'h00, 32'h1, 8'h0C);
    op("udiv short", ICT_CLS_DIV_UNSIGNED, 1'b0, 5'h00, 32'h80000000, 8'h02);
    op("sdiv", ICT_CLS_DIV_SIGNED, 1'b0, 5'h00, 32'hFFFFFFFF, 8'h0C);
  endtask
  task automatic t_events;
    issue(ICT_CLS_MUL_ACC, 1'b0, 5'h00, 32'h1);
    mwait <= 1'b1;
    repeat (2) @(posedge mclk_i);
    mwait <= 1'b0;
    fin("stalled mac", 2, 8'h04);
    op("barrier", ICT_CLS_BARRIER, 1'b0, 5'h00, 32'h1, 8'h04);
    @(posedge mclk_i);
    dly <= 8'h01;
    op("wfe", ICT_CLS_WAIT_FOR_EVENT_HINT, 1'b0, 5'h00, 32'h1, 8'h02);
    issue(ICT_CLS_WAIT_FOR_INTERRUPT_HINT, 1'b0, 5'h00, 32'h1);
    @(posedge mclk_i);
    irq <= 1'b1;
    @(posedge mclk_i);
    irq <= 1'b0;
    fin("wfi", 2, 8'h03);
  endtask
  task automatic t_restart;
    issue(ICT_CLS_UNSIGNED_LONG_MULTIPLY, 1'b0, 5'h00, 32'h12345678);
    @(posedge mclk_i);
    irq <= 1'b1;
    @(posedge mclk_i);
    irq <= 1'b0;
    @(negedge mclk_i);
    cmp("restart", 64'h1, {retire, restart});
    op("reissue", ICT_CLS_UNSIGNED_LONG_MULTIPLY, 1'b0, 5'h00, 32'h12345678, 8'h05);
  endtask

  // ==========================================================================
  // Verdict and sequence
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge mclk_i);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge mclk_i);
    cmp("ready in reset", 64'h0, ready);
    reset_n_i <= 1'b1;
    t_forms();
    t_loads();
    t_mul();
    t_div();
    t_events();
    t_restart();
    wrap_up();
  end
endmodule
